// ==== inc/bba_pkg.sv ====
package bba_pkg;
	// byte offsets of the bus registers
	localparam logic [9:0] BBA_OFS_CMD    = 10'h000;
	localparam logic [9:0] BBA_OFS_ACC    = 10'h004;
	localparam logic [9:0] BBA_OFS_STATUS = 10'h008;
	localparam logic [9:0] BBA_OFS_COUNT  = 10'h00c;
	// file window base: entry n sits at base + 4*n
	localparam logic [9:0] BBA_OFS_FILE   = 10'h200;
	// status word bit positions
	localparam int         BBA_ST_ZERO    = 0;
	localparam int         BBA_ST_CARRY   = 1;
	localparam int         BBA_ST_NIBBLE  = 2;
	localparam int         BBA_ST_SKIP    = 3;
	// sizes of the datapath
	localparam int         BBA_FILE_DEPTH = 128;
	// reset values
	localparam logic [7:0]  BBA_RST_ACC   = 8'h00;
	localparam logic [7:0]  BBA_RST_FILE  = 8'h00;
	localparam logic [2:0]  BBA_RST_FLAGS = 3'h0;
	localparam logic [15:0] BBA_RST_COUNT = 16'h0000;

	// operation codes of the command word
	typedef enum logic [3:0] {
		BBA_OP_NOP       = 4'b0000,
		BBA_OP_ADD_LIT   = 4'b0001,
		BBA_OP_AND_LIT   = 4'b0010,
		BBA_OP_ADD_REG   = 4'b0011,
		BBA_OP_AND_REG   = 4'b0100,
		BBA_OP_BIT_CLR   = 4'b0101,
		BBA_OP_BIT_SET   = 4'b0110,
		BBA_OP_SKIP_ONE  = 4'b0111,
		BBA_OP_SKIP_ZERO = 4'b1000,
		BBA_OP_ZERO_REG  = 4'b1001
	} bba_op_t;

	// command word as written to the command register
	typedef struct packed {
		logic [3:0] rsv3;
		bba_op_t    op;
		logic [2:0] rsv2;
		logic       dest;
		logic       rsv1;
		logic [2:0] bit_idx;
		logic       rsv0;
		logic [6:0] faddr;
		logic [7:0] literal;
	} bba_cmd_t;

	// status flags, zero in bit 0
	typedef struct packed {
		logic nibble_overflow_bit;
		logic carry;
		logic zero;
	} bba_flags_t;

	// outcome of one executed command
	typedef struct packed {
		logic [7:0] result;
		bba_flags_t flags;
		logic       flag_wr;
		logic       acc_wr;
		logic       file_wr;
		logic       skip;
	} bba_alu_t;
endpackage

// ==== core/bba_alu.sv ====
`timescale 1ns/1ps
module bba_alu import bba_pkg::*; (
	// command and operands
	input  wire bba_cmd_t   cmd,
	input  wire logic [7:0] acc,
	input  wire logic [7:0] fval,
	input  wire bba_flags_t flags_in,
	// outcome
	output bba_alu_t        res
);
	logic [7:0] bit_sel;  // one-hot bit selected by the index
	logic [7:0] opnd;     // second operand: literal or file entry
	logic [8:0] sum9;     // full sum with carry out of bit 7
	logic [4:0] sum5;     // low nibble sum with carry out of bit 3

	// one decoder per bit position
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_sel
			assign bit_sel[gi] = (cmd.bit_idx == 3'(gi));
		end
	endgenerate

	// flags not touched by an op are carried through unchanged
	always_comb begin
		opnd = ((cmd.op == BBA_OP_ADD_LIT) || (cmd.op == BBA_OP_AND_LIT)) ? cmd.literal : fval;
		sum9 = {1'b0, acc} + {1'b0, opnd};
		sum5 = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
		res = '0;
		res.flags = flags_in;
		case (cmd.op)
			BBA_OP_ADD_LIT, BBA_OP_ADD_REG: begin
				res.result = sum9[7:0];
				res.flags.carry = sum9[8];
				res.flags.nibble_overflow_bit = sum5[4];
				res.flags.zero = (sum9[7:0] == 8'h00);
				res.flag_wr = 1'b1;
				res.acc_wr = (cmd.op == BBA_OP_ADD_LIT) || !cmd.dest;
				res.file_wr = (cmd.op == BBA_OP_ADD_REG) && cmd.dest;
			end
			BBA_OP_AND_LIT, BBA_OP_AND_REG: begin
				res.result = acc & opnd;
				res.flags.zero = ((acc & opnd) == 8'h00);
				res.flag_wr = 1'b1;
				res.acc_wr = (cmd.op == BBA_OP_AND_LIT) || !cmd.dest;
				res.file_wr = (cmd.op == BBA_OP_AND_REG) && cmd.dest;
			end
			BBA_OP_BIT_CLR: begin
				res.result = fval & ~bit_sel;
				res.file_wr = 1'b1;
			end
			BBA_OP_BIT_SET: begin
				res.result = fval | bit_sel;
				res.file_wr = 1'b1;
			end
			BBA_OP_SKIP_ONE: begin
				res.skip = |(fval & bit_sel);
			end
			BBA_OP_SKIP_ZERO: begin
				res.skip = ~|(fval & bit_sel);
			end
			BBA_OP_ZERO_REG: begin
				res.result = 8'h00;
				res.flags.zero = 1'b1;
				res.flag_wr = 1'b1;
				res.file_wr = 1'b1;
			end
			default: begin
				// no-operation or unknown code: nothing changes
			end
		endcase
	end
endmodule

// ==== core/bba_ahb_slave.sv ====
`timescale 1ns/1ps
module bba_ahb_slave import bba_pkg::*; (
	// clock, reset, freeze
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// ahb-lite slave side
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	// register side
	output logic             wr_stb,
	output logic      [9:0]  reg_addr,
	output logic             reg_map,
	input  wire logic [31:0] rd_data
);
	logic       accept;      // address phase taken this edge
	logic       wr_pend_r;   // write data phase in progress
	logic       rd_pend_r;   // read data phase, first (wait) cycle
	logic [9:0] addr_r;      // latched word address
	logic       map_r;       // latched address lies in the map

	// only nonseq/seq transfers count; idle and busy are ignored
	assign accept = ce && hsel && hready && htrans[1];

	// reads stall one cycle so a write just before is visible
	assign hreadyout = ce && !rd_pend_r;
	assign wr_stb = ce && wr_pend_r;
	assign reg_addr = addr_r;
	assign reg_map = map_r;

	// address phase capture
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= 10'h000;
			map_r <= 1'b0;
		end else if (ce) begin
			wr_pend_r <= accept && hwrite;
			rd_pend_r <= accept && !hwrite;
			if (accept) begin
				addr_r <= {haddr[9:2], 2'b00};
				map_r <= (haddr[31:10] == 22'h000000);
			end
		end
	end

	// read data sampled in the wait cycle, held until the next read
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hrdata <= 32'h00000000;
		end else if (ce && rd_pend_r) begin
			hrdata <= rd_data;
		end
	end
endmodule

// ==== core/bba_core.sv ====
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - add literal to accumulator, update C, DC, Z
// - AND literal into accumulator, Z only
// - add accumulator and file register, update flags
// - destination bit picks accumulator or file register
// - AND accumulator with file register, Z only
// - bit clear leaves other bits, flags alone
// - bit set leaves other bits, flags alone
// - bit one skips next command as no-op
// - bit zero skips next command, no flags
// - zero register op clears entry, sets Z
module bba_core import bba_pkg::*; (
	// clock, reset, freeze
	CLK,
	RST_N,
	CE,
	// ahb-lite register bus
	HSEL,
	HADDR,
	HTRANS,
	HWRITE,
	HSIZE,
	HWDATA,
	HREADY,
	HRDATA,
	HREADYOUT,
	HRESP
);
	// clock, reset, freeze
	input  wire logic        CLK;
	input  wire logic        RST_N;
	input  wire logic        CE;
	// ahb-lite register bus
	input  wire logic        HSEL;
	input  wire logic [31:0] HADDR;
	input  wire logic [1:0]  HTRANS;
	input  wire logic        HWRITE;
	input  wire logic [2:0]  HSIZE;
	input  wire logic [31:0] HWDATA;
	input  wire logic        HREADY;
	output logic      [31:0] HRDATA;
	output logic             HREADYOUT;
	output logic             HRESP;

	// architectural state
	logic [7:0]  reg_file_r [BBA_FILE_DEPTH];  // data register file
	logic [7:0]  acc_r;                         // accumulator
	bba_flags_t  flags_r;                       // zero, carry, nibble carry
	logic        skip_r;                        // next command is discarded
	logic [15:0] count_r;                       // instruction cycles run
	bba_cmd_t    last_cmd_r;                    // last command word seen

	// bus side signals
	logic        wr_stb;     // write data phase, hwdata valid
	logic [9:0]  reg_addr;   // word-aligned register address
	logic        reg_map;    // upper address bits are clear
	logic [31:0] rd_data;    // value offered for a read

	// decode of the current write
	bba_cmd_t    cmd_w;      // hwdata seen as a command word
	logic [6:0]  faddr_w;    // file index named by the command
	logic [7:0]  fval_w;     // file entry named by the command
	logic [7:0]  lit_w;      // literal of the command
	logic [7:0]  bit_mask_w; // one-hot mask of the selected bit
	logic        bit_w;      // value of the selected bit
	logic        exec;       // a command is issued this cycle
	logic        run;        // issued and not discarded
	logic        hit_acc;    // write aimed at the accumulator
	logic        hit_stat;   // write aimed at the status word
	logic        hit_file;   // write aimed at the file window
	logic [6:0]  win_idx;    // file index from the bus address
	bba_alu_t    alu;        // outcome of the issued command

	// hsize is not checked: only whole words are ever issued
	assign HRESP = 1'b0;

	// bus front end
	bba_ahb_slave u_slave (
		.clk       (CLK),
		.rst_n     (RST_N),
		.ce        (CE),
		.hsel      (HSEL),
		.haddr     (HADDR),
		.htrans    (HTRANS),
		.hwrite    (HWRITE),
		.hready    (HREADY),
		.hrdata    (HRDATA),
		.hreadyout (HREADYOUT),
		.wr_stb    (wr_stb),
		.reg_addr  (reg_addr),
		.reg_map   (reg_map),
		.rd_data   (rd_data)
	);

	// command decode straight off the write data
	assign cmd_w = bba_cmd_t'(HWDATA);
	assign faddr_w = cmd_w.faddr;
	assign lit_w = cmd_w.literal;
	assign fval_w = reg_file_r[faddr_w];
	assign bit_mask_w = 8'h01 << cmd_w.bit_idx;
	assign bit_w = |(fval_w & bit_mask_w);

	// which register a write lands in
	assign exec = wr_stb && reg_map && (reg_addr == BBA_OFS_CMD);
	assign run = exec && !skip_r;
	assign hit_acc = wr_stb && reg_map && (reg_addr == BBA_OFS_ACC);
	assign hit_stat = wr_stb && reg_map && (reg_addr == BBA_OFS_STATUS);
	assign hit_file = wr_stb && reg_map && reg_addr[9];
	assign win_idx = reg_addr[8:2];

	// arithmetic and bit logic
	bba_alu u_alu (
		.cmd      (cmd_w),
		.acc      (acc_r),
		.fval     (fval_w),
		.flags_in (flags_r),
		.res      (alu)
	);

	// accumulator: software write or command result
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			acc_r <= BBA_RST_ACC;
		end else if (CE) begin
			if (hit_acc) begin
				acc_r <= HWDATA[7:0];
			end else if (run && alu.acc_wr) begin
				acc_r <= alu.result;
			end
		end
	end

	// status flags: bit ops and skips never reach here
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			flags_r <= bba_flags_t'(BBA_RST_FLAGS);
		end else if (CE) begin
			if (hit_stat) begin
				flags_r <= bba_flags_t'(HWDATA[2:0]);
			end else if (run && alu.flag_wr) begin
				flags_r <= alu.flags;
			end
		end
	end

	// skip pending: armed by a test, consumed by the next command
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			skip_r <= 1'b0;
		end else if (CE && exec) begin
			// a discarded command never arms a new skip
			skip_r <= run && alu.skip;
		end
	end

	// one count per command, a discarded one counts as its no-op cycle
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			count_r <= BBA_RST_COUNT;
		end else if (CE && exec) begin
			count_r <= count_r + 16'h0001;
		end
	end

	// last command word, kept for read back
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			last_cmd_r <= '0;
		end else if (CE && exec) begin
			last_cmd_r <= cmd_w;
		end
	end

	// file register: bus window write or command write back
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			for (int i = 0; i < BBA_FILE_DEPTH; i++) begin
				reg_file_r[i] <= BBA_RST_FILE;
			end
		end else if (CE) begin
			if (hit_file) begin
				reg_file_r[win_idx] <= HWDATA[7:0];
			end else if (run && alu.file_wr) begin
				reg_file_r[faddr_w] <= alu.result;
			end
		end
	end

	// read mux, unmapped addresses read as zero
	always_comb begin
		rd_data = 32'h00000000;
		if (reg_map) begin
			if (reg_addr[9]) begin
				rd_data = {24'h000000, reg_file_r[win_idx]};
			end else begin
				case (reg_addr)
					BBA_OFS_CMD: begin
						rd_data = last_cmd_r;
					end
					BBA_OFS_ACC: begin
						rd_data = {24'h000000, acc_r};
					end
					BBA_OFS_STATUS: begin
						rd_data[BBA_ST_ZERO] = flags_r.zero;
						rd_data[BBA_ST_CARRY] = flags_r.carry;
						rd_data[BBA_ST_NIBBLE] = flags_r.nibble_overflow_bit;
						rd_data[BBA_ST_SKIP] = skip_r;
					end
					BBA_OFS_COUNT: begin
						rd_data = {16'h0000, count_r};
					end
					default: begin
						rd_data = 32'h00000000;
					end
				endcase
			end
		end
	end

	// sum with carry and nibble carry written into the accumulator
	property p_add_lit;
		@(posedge CLK) disable iff (!RST_N)
		run && (cmd_w.op == BBA_OP_ADD_LIT)
		|=> ({flags_r.carry, acc_r} == ({1'b0, $past(acc_r)} + {1'b0, $past(lit_w)}))
		&& (flags_r.nibble_overflow_bit == ((5'($past(acc_r) & 8'h0f) + 5'($past(lit_w) & 8'h0f)) > 5'h0f));
	endproperty
	a_add_lit: assert property (p_add_lit) else $error("add literal result or carry wrong");

	// literal and keeps both carries
	property p_and_lit;
		@(posedge CLK) disable iff (!RST_N)
		run && (cmd_w.op == BBA_OP_AND_LIT)
		|=> (acc_r == ($past(acc_r) & $past(lit_w)))
		&& (flags_r.carry == $past(flags_r.carry))
		&& (flags_r.nibble_overflow_bit == $past(flags_r.nibble_overflow_bit));
	endproperty
	a_and_lit: assert property (p_and_lit) else $error("and literal result or flags wrong");

	// register add into the accumulator
	property p_add_reg;
		@(posedge CLK) disable iff (!RST_N)
		run && (cmd_w.op == BBA_OP_ADD_REG) && !cmd_w.dest
		|=> ({flags_r.carry, acc_r} == ({1'b0, $past(acc_r)} + {1'b0, $past(fval_w)}));
	endproperty
	a_add_reg: assert property (p_add_reg) else $error("add register result wrong");

	// destination one leaves the accumulator and updates the file entry
	property p_dest_file;
		@(posedge CLK) disable iff (!RST_N)
		run && ((cmd_w.op == BBA_OP_ADD_REG) || (cmd_w.op == BBA_OP_AND_REG)) && cmd_w.dest
		|=> (acc_r == $past(acc_r))
		&& (reg_file_r[$past(faddr_w)] == (($past(cmd_w.op) == BBA_OP_AND_REG) ? ($past(acc_r) & $past(fval_w))
		: 8'($past(acc_r) + $past(fval_w))));
	endproperty
	a_dest_file: assert property (p_dest_file) else $error("destination select ignored");

	// register and into the accumulator, zero follows the result, carry kept
	property p_and_reg;
		@(posedge CLK) disable iff (!RST_N)
		run && (cmd_w.op == BBA_OP_AND_REG) && !cmd_w.dest
		|=> (acc_r == ($past(acc_r) & $past(fval_w)))
		&& (flags_r.zero == (acc_r == 8'h00))
		&& (flags_r.carry == $past(flags_r.carry));
	endproperty
	a_and_reg: assert property (p_and_reg) else $error("and register result or flags wrong");

	// bit clear touches one bit and no flag
	property p_bit_clr;
		@(posedge CLK) disable iff (!RST_N)
		run && (cmd_w.op == BBA_OP_BIT_CLR)
		|=> (reg_file_r[$past(faddr_w)] == ($past(fval_w) & ~$past(bit_mask_w)))
		&& (flags_r == $past(flags_r));
	endproperty
	a_bit_clr: assert property (p_bit_clr) else $error("bit clear wrong");

	// bit set touches one bit and no flag
	property p_bit_set;
		@(posedge CLK) disable iff (!RST_N)
		run && (cmd_w.op == BBA_OP_BIT_SET)
		|=> (reg_file_r[$past(faddr_w)] == ($past(fval_w) | $past(bit_mask_w)))
		&& (flags_r == $past(flags_r));
	endproperty
	a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

	// test for one arms the skip exactly when the bit is one
	property p_skip_one;
		@(posedge CLK) disable iff (!RST_N)
		run && (cmd_w.op == BBA_OP_SKIP_ONE)
		|=> (skip_r == $past(bit_w)) && (flags_r == $past(flags_r));
	endproperty
	a_skip_one: assert property (p_skip_one) else $error("skip on one armed wrongly");

	// test for zero arms the skip exactly when the bit is zero
	property p_skip_zero;
		@(posedge CLK) disable iff (!RST_N)
		run && (cmd_w.op == BBA_OP_SKIP_ZERO)
		|=> (skip_r == !$past(bit_w)) && (flags_r == $past(flags_r));
	endproperty
	a_skip_zero: assert property (p_skip_zero) else $error("skip on zero armed wrongly");

	// a discarded command changes nothing but costs a cycle
	property p_discard;
		@(posedge CLK) disable iff (!RST_N)
		exec && skip_r
		|=> !skip_r && (acc_r == $past(acc_r)) && (flags_r == $past(flags_r))
		&& (count_r == ($past(count_r) + 16'h0001));
	endproperty
	a_discard: assert property (p_discard) else $error("skipped command was not discarded");

	// zero register op clears the entry and sets zero
	property p_zero_reg;
		@(posedge CLK) disable iff (!RST_N)
		run && (cmd_w.op == BBA_OP_ZERO_REG)
		|=> (reg_file_r[$past(faddr_w)] == 8'h00) && flags_r.zero;
	endproperty
	a_zero_reg: assert property (p_zero_reg) else $error("zero register op wrong");

	// zero flag follows the accumulator after literal ops
	property p_zero_flag;
		@(posedge CLK) disable iff (!RST_N)
		run && ((cmd_w.op == BBA_OP_ADD_LIT) || (cmd_w.op == BBA_OP_AND_LIT))
		|=> (flags_r.zero == (acc_r == 8'h00));
	endproperty
	a_zero_flag: assert property (p_zero_flag) else $error("zero flag disagrees with result");
endmodule

// ==== test/bba_ahb_model.sv ====
`timescale 1ns/1ps
// bus master standing in for the software side of the register bus
module bba_ahb_model (
	// clock
	input  wire logic        clk,
	// request toward the slave
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata,
	// answer from the slave
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	// bound on any wait for ready, so a stuck slave cannot hang the run
	localparam int WAIT_MAX = 64;

	// quiet bus at time zero
	initial begin
		hsel   = 1'b0;
		haddr  = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'h0;
	end

	// one single word transfer; called just after a rising edge
	task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
			output logic [31:0] rdata, output logic ok);
		int n;
		ok = 1'b0;
		rdata = 32'h0;
		hsel   <= 1'b1;
		haddr  <= addr;
		htrans <= 2'h2;
		hwrite <= wr;
		// address phase held until ready is seen
		for (n = 0; n < WAIT_MAX && !ok; n++) begin
			@(posedge clk);
			ok = (hready === 1'b1);
		end
		if (!ok) begin
			return;
		end
		htrans <= 2'h0;
		// idle address toggles so nothing can lean on a stale value
		haddr  <= ~addr;
		hwdata <= wr ? wdata : ~hwdata;
		ok = 1'b0;
		// data phase held until ready again; read data taken at that edge
		for (n = 0; n < WAIT_MAX && !ok; n++) begin
			@(posedge clk);
			ok = (hready === 1'b1);
		end
		rdata = hrdata;
		// released data lines carry the inverse, not the last word
		hwdata <= ~wdata;
	endtask
endmodule

// ==== test/bba_core_tb_top.sv ====
`timescale 1ns/1ps
module bba_core_tb_top import bba_pkg::*;;
	// bus and control wires
	logic        CLK;
	logic        RST_N;
	logic        CE;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	// reference state of the datapath
	logic [7:0]  m_acc;
	logic [2:0]  m_flg;
	logic        m_skip;
	logic [15:0] m_cnt;
	logic [7:0]  m_file [128];
	// counters of the verdict
	int          error_cnt;
	int          n_compared;
	// reserved bits of the command word, ignored by the core
	localparam logic [31:0] RSV_MASK = 32'hf0e88000;

	bba_core i_bba_core (
		.CLK(CLK), .RST_N(RST_N), .CE(CE), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp)
	);

	bba_ahb_model i_bba_ahb_model (
		.clk(CLK), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata)
	);

	// 25 MHz clock
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end

	// verdict and end of run
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// single compare point
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one bus transfer; a stall past the bound ends the run
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		logic ok;
		i_bba_ahb_model.xfer(wr, a, wd, rd, ok);
		if (!ok) begin
			error_cnt++;
			$display("ERROR hready expected 1 seen stall");
			complete_run();
		end else begin
			check("hresp", {31'h0, hresp}, 32'h0);
		end
	endtask

	// byte address of a file entry
	function automatic logic [31:0] fadr(input logic [6:0] fa);
		return {22'h0, BBA_OFS_FILE + {1'b0, fa, 2'b00}};
	endfunction

	// command word from its fields
	function automatic logic [31:0] word(input logic [3:0] op, input logic [7:0] lit, input logic [6:0] fa,
			input logic [2:0] b, input logic d);
		return {4'h0, op, 3'h0, d, 1'b0, b, 1'b0, fa, lit};
	endfunction

	// reference state back to its reset values
	function automatic void model_reset();
		m_acc  = 8'h00;
		m_flg  = 3'h0;
		m_skip = 1'b0;
		m_cnt  = 16'h0000;
		foreach (m_file[i]) m_file[i] = 8'h00;
	endfunction

	// expected effect of one command word
	function automatic void model_exec(input logic [31:0] w);
		logic [3:0] op;
		logic [7:0] fv;
		logic [7:0] opnd;
		logic [8:0] s;
		logic [4:0] nib;
		logic [7:0] r;
		op   = w[27:24];
		fv   = m_file[w[14:8]];
		opnd = (op == 4'h1 || op == 4'h2) ? w[7:0] : fv;
		m_cnt = m_cnt + 16'h1;
		// a pending skip swallows this word whole
		if (m_skip) begin
			m_skip = 1'b0;
			return;
		end
		s   = {1'b0, m_acc} + {1'b0, opnd};
		nib = {1'b0, m_acc[3:0]} + {1'b0, opnd[3:0]};
		r   = (op == 4'h2 || op == 4'h4) ? (m_acc & opnd) : s[7:0];
		case (op)
			4'h1, 4'h3: m_flg = {nib[4], s[8], r == 8'h00};
			4'h2, 4'h4: m_flg[0] = (r == 8'h00);
			4'h5: m_file[w[14:8]][w[18:16]] = 1'b0;
			4'h6: m_file[w[14:8]][w[18:16]] = 1'b1;
			4'h7: m_skip = fv[w[18:16]];
			4'h8: m_skip = !fv[w[18:16]];
			4'h9: begin
				m_file[w[14:8]] = 8'h00;
				m_flg[0] = 1'b1;
			end
			default: ;
		endcase
		// register forms route by the destination bit
		if (op >= 4'h1 && op <= 4'h4) begin
			if (op >= 4'h3 && w[20]) m_file[w[14:8]] = r;
			else m_acc = r;
		end
	endfunction

	// read back accumulator, status, count and one file entry
	task automatic check_state(input logic [6:0] fa);
		logic [31:0] v;
		bus(1'b0, {22'h0, BBA_OFS_ACC}, 32'h0, v);
		check("acc", v, {24'h0, m_acc});
		bus(1'b0, {22'h0, BBA_OFS_STATUS}, 32'h0, v);
		check("status", v, {28'h0, m_skip, m_flg});
		bus(1'b0, {22'h0, BBA_OFS_COUNT}, 32'h0, v);
		check("count", v, {16'h0, m_cnt});
		bus(1'b0, fadr(fa), 32'h0, v);
		check("file", v, {24'h0, m_file[fa]});
	endtask

	// issue a command and compare the outcome
	task automatic do_cmd(input logic [31:0] w);
		logic [31:0] v;
		bus(1'b1, {22'h0, BBA_OFS_CMD}, w, v);
		model_exec(w);
		// the whole word reads back, reserved bits and discarded ones too
		bus(1'b0, {22'h0, BBA_OFS_CMD}, 32'h0, v);
		check("cmd_back", v, w);
		check_state(w[14:8]);
	endtask

	// plain bus write that the reference mirrors
	task automatic poke(input logic [1:0] kind, input logic [6:0] fa, input logic [7:0] d);
		logic [31:0] v;
		case (kind)
			2'h0: begin
				bus(1'b1, {22'h0, BBA_OFS_ACC}, {24'h0, d}, v);
				m_acc = d;
			end
			2'h1: begin
				bus(1'b1, {22'h0, BBA_OFS_STATUS}, {24'h0, d}, v);
				m_flg = d[2:0];
			end
			default: begin
				bus(1'b1, fadr(fa), {24'h0, d}, v);
				m_file[fa] = d;
			end
		endcase
	endtask

	// main sequence
	initial begin
		logic [31:0] v;
		logic [31:0] r;
		logic [6:0]  fa;
		logic [3:0]  op;
		error_cnt  = 0;
		n_compared = 0;
		CE    = 1'b1;
		RST_N = 1'b0;
		void'($urandom(32'h6f29));
		model_reset();
		repeat (10) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);

		// reset values and unmapped places
		check_state(7'h00);
		check_state(7'h7f);
		bus(1'b0, {22'h0, BBA_OFS_CMD}, 32'h0, v);
		check("cmd", v, 32'h0);
		bus(1'b1, 32'h0000_0010, 32'hffff_ffff, v);
		bus(1'b0, 32'h0000_0010, 32'h0, v);
		check("unmapped", v, 32'h0);
		bus(1'b0, 32'h0000_0400, 32'h0, v);
		check("unmapped_hi", v, 32'h0);
		check_state(7'h00);
		$display("test reset done");

		// every operation with carry, nibble and skip corners
		poke(2'h0, 7'h0, 8'h0f);
		poke(2'h2, 7'h05, 8'h80);
		do_cmd(word(BBA_OP_ADD_LIT, 8'h01, 7'h05, 3'h0, 1'b0));
		do_cmd(word(BBA_OP_ADD_LIT, 8'hf0, 7'h05, 3'h0, 1'b0));
		do_cmd(word(BBA_OP_ADD_LIT, 8'hff, 7'h05, 3'h0, 1'b0));
		do_cmd(word(BBA_OP_AND_LIT, 8'h0f, 7'h05, 3'h0, 1'b0));
		do_cmd(word(BBA_OP_ADD_REG, 8'h00, 7'h05, 3'h0, 1'b1));
		do_cmd(word(BBA_OP_AND_REG, 8'h00, 7'h05, 3'h0, 1'b0));
		do_cmd(word(BBA_OP_AND_REG, 8'h00, 7'h7f, 3'h0, 1'b1));
		do_cmd(word(BBA_OP_BIT_SET, 8'h00, 7'h05, 3'h6, 1'b0));
		do_cmd(word(BBA_OP_BIT_CLR, 8'h00, 7'h05, 3'h7, 1'b0));
		do_cmd(word(BBA_OP_ZERO_REG, 8'h00, 7'h06, 3'h0, 1'b0));
		do_cmd(word(BBA_OP_SKIP_ONE, 8'h00, 7'h05, 3'h6, 1'b0));
		do_cmd(word(BBA_OP_ADD_LIT, 8'h01, 7'h05, 3'h0, 1'b0));
		do_cmd(word(BBA_OP_SKIP_ZERO, 8'h00, 7'h05, 3'h7, 1'b0));
		// a bus write in between must not use up the skip
		poke(2'h0, 7'h0, 8'h33);
		do_cmd(word(BBA_OP_ZERO_REG, 8'h00, 7'h05, 3'h0, 1'b0));
		do_cmd(word(BBA_OP_SKIP_ONE, 8'h00, 7'h05, 3'h0, 1'b0));
		do_cmd(word(BBA_OP_SKIP_ZERO, 8'h00, 7'h05, 3'h1, 1'b0));
		do_cmd(word(BBA_OP_NOP, 8'hff, 7'h05, 3'h0, 1'b0));
		do_cmd(word(4'hf, 8'hff, 7'h05, 3'h0, 1'b0));
		$display("test directed done");

		// random mix of commands and bus writes, reserved bits set too
		for (int i = 0; i < 200; i++) begin
			r  = $urandom;
			fa = r[0] ? {4'h0, r[3:1]} : r[10:4];
			op = ($urandom_range(0, 10) == 10) ? 4'hf : 4'($urandom_range(0, 9));
			if (r[11] && r[12]) begin
				poke(r[14:13], fa, r[31:24]);
				check_state(fa);
			end else begin
				do_cmd(word(op, r[31:24], fa, r[17:15], r[18]) | (r & RSV_MASK));
			end
		end
		$display("test random done");

		// clock enable low freezes and stalls the bus
		CE <= 1'b0;
		repeat (3) @(posedge CLK);
		check("hreadyout", {31'h0, hreadyout}, 32'h0);
		// a command offered while frozen waits, then runs exactly once
		fork
			do_cmd(word(BBA_OP_ADD_LIT, 8'h5a, 7'h05, 3'h0, 1'b0));
			begin
				repeat (4) @(posedge CLK);
				CE <= 1'b1;
			end
		join
		@(posedge CLK);
		check_state(7'h05);
		$display("test freeze done");

		// second reset in mid-run
		RST_N <= 1'b0;
		repeat (2) @(posedge CLK);
		RST_N <= 1'b1;
		model_reset();
		@(posedge CLK);
		check_state(7'h05);
		$display("test rereset done");
		complete_run();
	end
endmodule
